// ==== common/instr_timing_pkg.sv ====
// package: opcodes, sizes, operand forms and clock counts for the timing model
package instr_timing_pkg;
  // operation selector
  typedef enum logic [3:0]
  {
    OP_ADD = 4'h0,
    OP_AND = 4'h1,
    OP_CMP = 4'h2,
    OP_OR = 4'h3,
    OP_SUB = 4'h4,
    OP_EXCLUSIVE_OR = 4'h5,
    OP_SIGNED_MULTIPLY = 4'h6,
    OP_UNSIGNED_MULTIPLY = 4'h7,
    OP_SIGNED_DIVIDE = 4'h8,
    OP_UNSIGNED_DIVIDE = 4'h9,
    OP_ADD_QUICK = 4'ha,
    OP_SUB_QUICK = 4'hb,
    OP_MOVE_QUICK = 4'hc
  } op_t;
  // operand size
  typedef enum logic [1:0]
  {
    SZ_BYTE = 2'h0,
    SZ_WORD = 2'h1,
    SZ_LONG = 2'h2
  } size_t;
  // operand form: std source-to-register, register-to-memory, immediate forms
  typedef enum logic [2:0]
  {
    FORM_EA_TO_DATA = 3'h0,
    FORM_EA_TO_ADDR = 3'h1,
    FORM_DATA_TO_MEM = 3'h2,
    FORM_IMM_TO_DATA = 3'h3,
    FORM_IMM_TO_ADDR = 3'h4,
    FORM_IMM_TO_MEM = 3'h5
  } form_t;
  // engine states
  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_COUNT = 2'h1,
    ST_DONE = 2'h2
  } state_t;

  localparam int CLK_W = 8;
  localparam int BUS_W = 5;
  localparam logic [CLK_W-1:0] MUL_BASE = 8'h2a; // 42 clocks
  localparam logic [CLK_W-1:0] MUL_MAX = 8'h4a; // 74 clocks
  localparam logic [CLK_W-1:0] SDIV_MAX = 8'ha2; // 162 clocks
  localparam logic [CLK_W-1:0] UDIV_MAX = 8'h90; // 144 clocks
  localparam logic [CLK_W-1:0] T8 = 8'h08;
  localparam logic [CLK_W-1:0] T10 = 8'h0a;
  localparam logic [CLK_W-1:0] T12 = 8'h0c;
  localparam logic [CLK_W-1:0] T16 = 8'h10;
  localparam logic [CLK_W-1:0] T20 = 8'h14;
  localparam logic [CLK_W-1:0] T24 = 8'h18;
  localparam logic [CLK_W-1:0] T26 = 8'h1a;
  localparam logic [CLK_W-1:0] T28 = 8'h1c;
  localparam logic [CLK_W-1:0] T40 = 8'h28;
  localparam logic [BUS_W-1:0] R0 = 5'h00;
  localparam logic [BUS_W-1:0] R1 = 5'h01;
  localparam logic [BUS_W-1:0] R2 = 5'h02;
  localparam logic [BUS_W-1:0] R4 = 5'h04;
  localparam logic [BUS_W-1:0] R6 = 5'h06;
endpackage

// ==== common/timing_if.sv ====
// interface: one timing entry passed between the decoder modules
`timescale 1ns/1ps
`default_nettype none
interface timing_if;
  logic [instr_timing_pkg::CLK_W-1:0] clocks;
  logic [instr_timing_pkg::BUS_W-1:0] reads;
  logic [instr_timing_pkg::BUS_W-1:0] writes;
  logic legal;
  logic add_ea;
  modport src
  (
    output clocks,
    output reads,
    output writes,
    output legal,
    output add_ea
  );
  modport dst
  (
    input clocks,
    input reads,
    input writes,
    input legal,
    input add_ea
  );
endinterface
`default_nettype wire

// ==== hdl/mul_count.sv ====
// multiply data-dependent count n from the source operand
`timescale 1ns/1ps
`default_nettype none
module mul_count
(
  input wire logic [15:0] operand,
  input wire logic is_signed,
  output logic [4:0] n_count
);
  // =====================================================
  // per-bit terms: transitions for signed, ones for unsigned
  logic [15:0] term;
  logic [16:0] ext;
  assign ext = {operand, 1'b0}; // zero below the lsb gives 17 bits
  genvar i;
  generate
    for (i = 0; i < 16; i++)
    begin : g_term
      assign term[i] = is_signed ? (ext[i+1] ^ ext[i]) : operand[i];
    end
  endgenerate
  // adder tree written as a loop; result fits in 5 bits
  always_comb
  begin
    n_count = 5'h00;
    for (int k = 0; k < 16; k++)
    begin
      n_count = n_count + {4'h0, term[k]};
    end
  end
endmodule
`default_nettype wire

// ==== hdl/base_table.sv ====
// base timing lookup for standard and immediate instructions
`timescale 1ns/1ps
`default_nettype none
module base_table
(
  input wire logic [3:0] op,
  input wire logic [1:0] size,
  input wire logic [2:0] form,
  input wire logic src_reg_or_imm,
  timing_if.src entry
);
  // =====================================================
  // table lookup: base clocks, reads, writes, plus-sign flag
  always_comb
  begin
    entry.clocks = instr_timing_pkg::T8;
    entry.reads = instr_timing_pkg::R2;
    entry.writes = instr_timing_pkg::R0;
    entry.legal = 1'b1;
    entry.add_ea = 1'b1;
    case (instr_timing_pkg::form_t'(form))
      instr_timing_pkg::FORM_EA_TO_DATA:
      begin
        case (instr_timing_pkg::op_t'(op))
          instr_timing_pkg::OP_ADD, instr_timing_pkg::OP_AND,
          instr_timing_pkg::OP_OR, instr_timing_pkg::OP_SUB:
          begin
            if (size == instr_timing_pkg::SZ_LONG)
              entry.clocks = src_reg_or_imm ? instr_timing_pkg::T12 : instr_timing_pkg::T10;
          end
          instr_timing_pkg::OP_CMP:
          begin
            if (size == instr_timing_pkg::SZ_LONG)
              entry.clocks = instr_timing_pkg::T10;
          end
          instr_timing_pkg::OP_EXCLUSIVE_OR:
          begin
            entry.legal = src_reg_or_imm;
            if (size == instr_timing_pkg::SZ_LONG)
              entry.clocks = instr_timing_pkg::T12;
          end
          instr_timing_pkg::OP_SIGNED_MULTIPLY, instr_timing_pkg::OP_UNSIGNED_MULTIPLY:
            entry.clocks = instr_timing_pkg::MUL_MAX;
          instr_timing_pkg::OP_SIGNED_DIVIDE:
            entry.clocks = instr_timing_pkg::SDIV_MAX;
          instr_timing_pkg::OP_UNSIGNED_DIVIDE:
            entry.clocks = instr_timing_pkg::UDIV_MAX;
          default:
            entry.legal = 1'b0;
        endcase
      end
      instr_timing_pkg::FORM_EA_TO_ADDR:
      begin
        case (instr_timing_pkg::op_t'(op))
          instr_timing_pkg::OP_CMP:
          begin
            entry.clocks = instr_timing_pkg::T10;
            entry.legal = (size != instr_timing_pkg::SZ_BYTE);
          end
          instr_timing_pkg::OP_SUB:
          begin
            entry.legal = (size != instr_timing_pkg::SZ_BYTE);
            if (size == instr_timing_pkg::SZ_LONG)
              entry.clocks = src_reg_or_imm ? instr_timing_pkg::T12 : instr_timing_pkg::T10;
            else
              entry.clocks = instr_timing_pkg::T12;
          end
          default:
            entry.legal = 1'b0;
        endcase
      end
      instr_timing_pkg::FORM_DATA_TO_MEM:
      begin
        entry.legal = (op <= 4'h5) && (op != 4'h2);
        case (instr_timing_pkg::size_t'(size))
          instr_timing_pkg::SZ_BYTE:
          begin
            entry.clocks = instr_timing_pkg::T12;
            entry.writes = instr_timing_pkg::R1;
          end
          instr_timing_pkg::SZ_WORD:
          begin
            entry.clocks = instr_timing_pkg::T16;
            entry.writes = instr_timing_pkg::R2;
          end
          default:
          begin
            entry.clocks = instr_timing_pkg::T24;
            entry.writes = instr_timing_pkg::R4;
          end
        endcase
      end
      instr_timing_pkg::FORM_IMM_TO_DATA:
      begin
        entry.add_ea = 1'b0;
        if (op >= 4'ha)
          entry.clocks = (size == instr_timing_pkg::SZ_LONG || op == 4'hc) ?
            ((op == 4'hc) ? instr_timing_pkg::T8 : instr_timing_pkg::T12) : instr_timing_pkg::T8;
        else if (size == instr_timing_pkg::SZ_LONG)
        begin
          entry.clocks = (op == 4'h2) ? instr_timing_pkg::T26 : instr_timing_pkg::T28;
          entry.reads = instr_timing_pkg::R6;
        end
        else
        begin
          entry.clocks = instr_timing_pkg::T16;
          entry.reads = instr_timing_pkg::R4;
        end
        // codes above the one-word load are unassigned and refused
        entry.legal = (op <= 4'h5 || (op >= 4'ha && op <= 4'hc)) && (op != 4'hc || size == 2'h2);
      end
      instr_timing_pkg::FORM_IMM_TO_ADDR:
      begin
        entry.add_ea = 1'b0;
        entry.clocks = instr_timing_pkg::T12;
        entry.legal = (op == 4'ha || op == 4'hb) && (size != instr_timing_pkg::SZ_BYTE);
      end
      default:
      begin
        // immediate to memory
        entry.legal = (op <= 4'h5 || op == 4'ha || op == 4'hb) && (form == 3'h5);
        if (op == 4'h2)
        begin
          entry.add_ea = 1'b0;
          entry.clocks = (size == 2'h2) ? instr_timing_pkg::T24 : instr_timing_pkg::T16;
          entry.reads = (size == 2'h2) ? instr_timing_pkg::R6 : instr_timing_pkg::R4;
        end
        else if (op == 4'ha || op == 4'h4)
        begin
          entry.clocks = (size == 2'h0) ? instr_timing_pkg::T12 :
            ((size == 2'h1) ? instr_timing_pkg::T16 : instr_timing_pkg::T24);
          entry.writes = (size == 2'h0) ? instr_timing_pkg::R1 :
            ((size == 2'h1) ? instr_timing_pkg::R2 : instr_timing_pkg::R4);
        end
        else
        begin
          entry.clocks = (size == 2'h0) ? instr_timing_pkg::T20 :
            ((size == 2'h1) ? instr_timing_pkg::T24 : instr_timing_pkg::T40);
          entry.reads = (size == 2'h2) ? instr_timing_pkg::R6 : instr_timing_pkg::R4;
          entry.writes = (size == 2'h0) ? instr_timing_pkg::R1 :
            ((size == 2'h1) ? instr_timing_pkg::R2 : instr_timing_pkg::R4);
        end
      end
    endcase
  end
endmodule
`default_nettype wire

// ==== hdl/arith_instr_cycle_timing.sv ====
// timing model: clocks, reads and writes charged per arithmetic instruction
// Behaviour
// [RQ1] standard counts include operation, result store and next-word prefetch
// [RQ2] immediate counts also include fetching the immediate operand words
// [RQ3] plus-marked entries add the address calculation's clocks, reads and writes
// [RQ4] multiply takes 42 plus twice n clocks
// [RQ5] signed multiply n counts 10/01 pairs in source with zero appended below
// [RQ6] unsigned multiply n is the number of one bits in the source
// [RQ7] multiply to data register: at most 74 clocks, two reads, no writes, plus ea
// [RQ8] signed divide at most 162, unsigned 144; spread under ten percent
// [RQ9] long add/and/or/sub to data register: 12 not 10 for register or immediate source
// [RQ10] exclusive-or to data register only from data register: 8 or 12 clocks
// [RQ11] each instruction reports total clocks, reads and writes separately
`timescale 1ns/1ps
`default_nettype none
module arith_instr_cycle_timing
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [3:0] op,
  input wire logic [1:0] size,
  input wire logic [2:0] form,
  input wire logic src_reg_or_imm,
  input wire logic [15:0] source_operand,
  input wire logic [7:0] ea_clocks,
  input wire logic [4:0] ea_reads,
  input wire logic [4:0] ea_writes,
  output logic busy,
  output logic done,
  output logic illegal,
  output logic [7:0] total_clocks,
  output logic [4:0] total_reads,
  output logic [4:0] total_writes
);
  // =====================================================
  // decode
  timing_if entry();
  logic [4:0] n_count;
  logic is_mul;
  logic [7:0] base_clocks;
  logic [7:0] sum_clocks;
  logic [4:0] sum_reads;
  logic [4:0] sum_writes;

  // table entry for the decoded instruction
  base_table u_table
  (
    .op(op),
    .size(size),
    .form(form),
    .src_reg_or_imm(src_reg_or_imm),
    .entry(entry)
  );

  // operand-dependent count, only used for multiply
  mul_count u_mul
  (
    .operand(source_operand),
    .is_signed(op == 4'h6),
    .n_count(n_count)
  );

  // data-dependent multiply replaces the worst-case table figure
  always_comb
  begin
    is_mul = (form == 3'h0) && (op == 4'h6 || op == 4'h7);
    if (is_mul)
      base_clocks = instr_timing_pkg::MUL_BASE + {2'h0, n_count, 1'b0}; // [RQ4] [RQ5] [RQ6]
    else
      base_clocks = entry.clocks; // [RQ1] [RQ2] [RQ8] [RQ9] [RQ10]
    sum_clocks = base_clocks + (entry.add_ea ? ea_clocks : 8'h00); // [RQ3] [RQ7]
    sum_reads = entry.reads + (entry.add_ea ? ea_reads : 5'h00); // [RQ3]
    sum_writes = entry.writes + (entry.add_ea ? ea_writes : 5'h00); // [RQ3]
  end

  // =====================================================
  // execution counter: busy for one cycle less than the charged number of clocks, then done
  instr_timing_pkg::state_t state_q;
  instr_timing_pkg::state_t state_d;
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic [7:0] clk_q;
  logic [7:0] clk_d;
  logic [4:0] rd_q;
  logic [4:0] rd_d;
  logic [4:0] wr_q;
  logic [4:0] wr_d;
  logic ill_q;
  logic ill_d;
  logic busy_q;
  logic busy_d;
  logic done_q;
  logic done_d;

  // new starts are ignored while busy, so the counter never restarts mid-op
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    clk_d = clk_q;
    rd_d = rd_q;
    wr_d = wr_q;
    ill_d = ill_q;
    busy_d = busy_q;
    done_d = 1'b0;
    case (state_q)
      instr_timing_pkg::ST_IDLE:
      begin
        if (start)
        begin
          ill_d = ~entry.legal;
          if (entry.legal)
          begin
            clk_d = sum_clocks; // [RQ11]
            rd_d = sum_reads; // [RQ11]
            wr_d = sum_writes; // [RQ11]
            cnt_d = sum_clocks - 8'h01;
            busy_d = 1'b1;
            state_d = instr_timing_pkg::ST_COUNT;
          end
          else
          begin
            clk_d = 8'h00;
            rd_d = 5'h00;
            wr_d = 5'h00;
            done_d = 1'b1;
          end
        end
      end
      instr_timing_pkg::ST_COUNT:
      begin
        if (cnt_q <= 8'h01)
        begin
          busy_d = 1'b0;
          done_d = 1'b1;
          state_d = instr_timing_pkg::ST_IDLE;
        end
        else
          cnt_d = cnt_q - 8'h01;
      end
      default:
        state_d = instr_timing_pkg::ST_IDLE;
    endcase
  end

  // synchronous reset
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
    begin
      state_q <= instr_timing_pkg::ST_IDLE;
      cnt_q <= 8'h00;
      clk_q <= 8'h00;
      rd_q <= 5'h00;
      wr_q <= 5'h00;
      ill_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      clk_q <= clk_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      ill_q <= ill_d;
      busy_q <= busy_d;
      done_q <= done_d;
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign illegal = ill_q;
  assign total_clocks = clk_q;
  assign total_reads = rd_q;
  assign total_writes = wr_q;

  // =====================================================
  // checks
  // launch-time copies, so next-cycle checks see what was taken
  logic [4:0] n_count_q1;
  logic [7:0] ea_q1;
  logic taken;
  logic [7:0] busy_len_q;
  logic [7:0] busy_len_d;

  // a launch is a start seen while idle
  assign taken = start && !busy_q;

  // plain copies, rewritten every cycle, so no reset
  always_ff @(posedge clk_sys)
  begin
    n_count_q1 <= n_count;
    ea_q1 <= ea_clocks;
  end

  // busy run length; a counter, as a long repetition would stall the tools
  always_comb
  begin
    busy_len_d = 8'h00;
    if (busy_q)
      busy_len_d = busy_len_q + 8'h01;
  end

  // busy run register
  always_ff @(posedge clk_sys)
  begin
    if (!rst_b)
      busy_len_q <= 8'h00;
    else
      busy_len_q <= busy_len_d;
  end

  // multiply time follows the operand
  a_mul_formula : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ4]
    (taken && is_mul)
    |=> (total_clocks == instr_timing_pkg::MUL_BASE + {2'h0, n_count_q1, 1'b0} + ea_q1))
    else $error("multiply clocks wrong");

  // ceiling kept, no writes of its own
  a_mul_bound : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ7]
    (taken && is_mul)
    |-> (base_clocks <= instr_timing_pkg::MUL_MAX && sum_writes == ea_writes))
    else $error("multiply exceeds 74 or writes");

  // unsigned count is the ones count
  a_umul_pop : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ6]
    (is_mul && op == 4'h7)
    |-> (n_count == 5'($countones(source_operand))))
    else $error("unsigned n not popcount");

  // alternating source is the signed worst case
  a_smul_worst : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ5]
    (is_mul && op == 4'h6 && source_operand == 16'h5555)
    |-> (n_count == 5'h10))
    else $error("signed n worst case wrong");

  // signed divide charges its maximum
  a_div_time : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ8]
    (taken && form == 3'h0 && op == 4'h8)
    |=> (total_clocks == instr_timing_pkg::SDIV_MAX + ea_q1))
    else $error("signed divide clocks wrong");

  // unsigned divide charges its maximum
  a_udiv_time : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ8]
    (taken && form == 3'h0 && op == 4'h9)
    |=> (total_clocks == instr_timing_pkg::UDIV_MAX + ea_q1))
    else $error("unsigned divide clocks wrong");

  // long add, and, or, sub into data register
  a_long_reg_src : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ9]
    (form == 3'h0 && size == 2'h2 && op != 4'h2 && op <= 4'h4)
    |-> (base_clocks == (src_reg_or_imm ? instr_timing_pkg::T12 : instr_timing_pkg::T10)))
    else $error("long add base wrong");

  // other source modes refused
  a_xor_source : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ10]
    (taken && form == 3'h0 && op == 4'h5 && !src_reg_or_imm)
    |=> (illegal && done))
    else $error("exclusive-or source not refused");

  // exclusive-or base time by size
  a_xor_time : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ10]
    (form == 3'h0 && op == 4'h5 && src_reg_or_imm)
    |-> (base_clocks == ((size == 2'h2) ? instr_timing_pkg::T12 : instr_timing_pkg::T8)))
    else $error("exclusive-or clocks wrong");

  // operand fetch included, no address time
  a_imm_reads : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ2]
    (form == 3'h3 && op == 4'h0 && size == 2'h2)
    |-> (sum_reads == 5'h06 && sum_clocks == 8'h1c))
    else $error("long immediate add wrong");

  // shortest entry: seven busy cycles, then done
  a_done_time : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ1]
    (taken && entry.legal && sum_clocks == 8'h08)
    |=> busy[*7] ##1 done)
    else $error("busy length wrong");

  // any legal entry holds busy one cycle short of its total
  a_busy_length : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ11]
    (done && !illegal)
    |-> (busy_len_q == total_clocks - 8'h01))
    else $error("busy run does not match total");

  // a refused entry reports nothing
  a_refused_zero : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ11]
    (done && illegal)
    |-> (total_clocks == 8'h00 && total_reads == 5'h00 && total_writes == 5'h00 && !busy))
    else $error("refused entry has totals");

  // a start while busy leaves the totals alone
  a_start_ignored : assert property (@(posedge clk_sys) disable iff (!rst_b) // [RQ11]
    (busy_q && start)
    |=> ($stable(total_clocks) && $stable(total_reads) && $stable(total_writes)))
    else $error("start taken while busy");

  // main scenarios reached
  c_mul : cover property (@(posedge clk_sys) taken && is_mul);
  c_div : cover property (@(posedge clk_sys) taken && op == 4'h9 && form == 3'h0);
  c_imm_mem : cover property (@(posedge clk_sys) taken && form == 3'h5);
  c_illegal : cover property (@(posedge clk_sys) done && illegal);
  c_poke : cover property (@(posedge clk_sys) busy_q && start);
endmodule
`default_nettype wire

// ==== bench/testbench.sv ====
// self-checking testbench for the arithmetic instruction timing model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  // ==========================================
  // signals and counters
  logic clk_sys;
  logic rst_b;
  logic start;
  logic [3:0] op;
  logic [1:0] size;
  logic [2:0] form;
  logic src_reg_or_imm;
  logic [15:0] source_operand;
  logic [7:0] ea_clocks;
  logic [4:0] ea_reads;
  logic [4:0] ea_writes;
  logic busy;
  logic done;
  logic illegal;
  logic [7:0] total_clocks;
  logic [4:0] total_reads;
  logic [4:0] total_writes;
  int error_cnt;
  int num_checks;
  int seed;

  arith_instr_cycle_timing arith_instr_cycle_timing_i
  (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .start(start),
    .op(op),
    .size(size),
    .form(form),
    .src_reg_or_imm(src_reg_or_imm),
    .source_operand(source_operand),
    .ea_clocks(ea_clocks),
    .ea_reads(ea_reads),
    .ea_writes(ea_writes),
    .busy(busy),
    .done(done),
    .illegal(illegal),
    .total_clocks(total_clocks),
    .total_reads(total_reads),
    .total_writes(total_writes)
  );

  // ==========================================
  // clock, 4 ns period
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // ==========================================
  // compare tasks and verdict
  task automatic chk_num(input logic [7:0] got, input logic [7:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %0d expected %0d", $time, what, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // expected multiply n: signed counts level changes in source with a zero below
  function automatic int mul_n(input logic sgn, input logic [15:0] v);
    logic [16:0] x;
    int n;
    x = {v, 1'b0};
    n = 0;
    for (int i = 0; i < 16; i++)
      n += sgn ? int'(x[i+1] != x[i]) : int'(v[i]);
    return n;
  endfunction

  // ==========================================
  // one instruction: launch, wait for done, compare totals and timing
  task automatic run_instr(input logic [3:0] o, input logic [1:0] s, input logic [2:0] f,
    input logic sri, input logic [15:0] src, input logic [7:0] ec, input logic [4:0] er,
    input logic [4:0] ew, input logic [7:0] xc, input logic [4:0] xr, input logic [4:0] xw,
    input logic xill, input logic poke);
    int k;
    @(negedge clk_sys);
    op = o;
    size = s;
    form = f;
    src_reg_or_imm = sri;
    source_operand = src;
    ea_clocks = ec;
    ea_reads = er;
    ea_writes = ew;
    start = 1'b1;
    @(negedge clk_sys);
    start = 1'b0;
    chk_bit(illegal, xill, "illegal flag");
    k = 1;
    // a poke while busy must be ignored, so totals stay those of this launch
    while (done !== 1'b1 && k < 300)
    begin
      @(negedge clk_sys);
      k++;
      start = poke && (k == 2);
      if (poke && k == 2)
        op = instr_timing_pkg::OP_ADD;
    end
    chk_num(8'(k), xill ? 8'h01 : xc, "done cycle");
    chk_bit(busy, 1'b0, "busy at done");
    chk_num(total_clocks, xc, "clocks");
    chk_num({3'h0, total_reads}, {3'h0, xr}, "reads");
    chk_num({3'h0, total_writes}, {3'h0, xw}, "writes");
  endtask

  // ==========================================
  // watchdog: whole run needs well under 10000 cycles
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    $display("CHECK FAILED at %0t: run did not finish", $time);
    print_verdict();
  end

  // ==========================================
  // main sequence
  initial
  begin
    logic [15:0] v;
    logic [7:0] ec;
    logic [4:0] er;
    logic sgn;
    logic [3:0] fam [4];
    int n;
    fam = '{instr_timing_pkg::OP_ADD, instr_timing_pkg::OP_AND,
      instr_timing_pkg::OP_OR, instr_timing_pkg::OP_SUB};
    seed = 50;
    error_cnt = 0;
    num_checks = 0;
    rst_b = 1'b0;
    start = 1'b0;
    op = 4'h0;
    size = 2'h0;
    form = 3'h0;
    src_reg_or_imm = 1'b0;
    source_operand = 16'h0000;
    ea_clocks = 8'h00;
    ea_reads = 5'h00;
    ea_writes = 5'h00;
    repeat (5) @(negedge clk_sys);
    rst_b = 1'b1;
    // plain standard entries, with and without address time
    run_instr(4'h0, 2'h1, 3'h0, 1'b0, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h08, 5'h02, 5'h00, 1'b0, 1'b0);
    run_instr(4'h0, 2'h1, 3'h0, 1'b0, 16'h0000, 8'h06, 5'h01, 5'h00,
      8'h0e, 5'h03, 5'h00, 1'b0, 1'b0);
    run_instr(4'h4, 2'h0, 3'h2, 1'b0, 16'h0000, 8'h04, 5'h01, 5'h00,
      8'h10, 5'h03, 5'h01, 1'b0, 1'b0);
    run_instr(4'h0, 2'h2, 3'h2, 1'b0, 16'h0000, 8'h0a, 5'h02, 5'h01,
      8'h22, 5'h04, 5'h05, 1'b0, 1'b0);
    // long logic and arithmetic into data register: 10 or 12 base, random address time
    for (int i = 0; i < 8; i++)
    begin
      ec = 8'($random(seed)) & 8'h0e;
      er = 5'($random(seed)) & 5'h03;
      run_instr(fam[i % 4], 2'h2, 3'h0, 1'(i / 4), 16'h0000, ec, er, 5'h00,
        ((i / 4) ? 8'h0c : 8'h0a) + ec, 5'h02 + er, 5'h00, 1'b0, 1'b0);
    end
    // immediate forms include the operand fetch
    run_instr(4'h0, 2'h1, 3'h3, 1'b1, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h10, 5'h04, 5'h00, 1'b0, 1'b0);
    run_instr(4'h0, 2'h2, 3'h3, 1'b1, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h1c, 5'h06, 5'h00, 1'b0, 1'b0);
    run_instr(4'h1, 2'h0, 3'h5, 1'b1, 16'h0000, 8'h08, 5'h02, 5'h00,
      8'h1c, 5'h06, 5'h01, 1'b0, 1'b0);
    // exclusive-or into data register only from a data register
    run_instr(4'h5, 2'h0, 3'h0, 1'b1, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h08, 5'h02, 5'h00, 1'b0, 1'b0);
    run_instr(4'h5, 2'h2, 3'h0, 1'b1, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h0c, 5'h02, 5'h00, 1'b0, 1'b0);
    run_instr(4'h5, 2'h1, 3'h0, 1'b0, 16'h0000, 8'h04, 5'h01, 5'h00,
      8'h00, 5'h00, 5'h00, 1'b1, 1'b0);
    // address-register, compare, quick and one-word-load forms, and an unused code
    run_instr(4'h2, 2'h1, 3'h1, 1'b0, 16'h0000, 8'h04, 5'h01, 5'h00,
      8'h0e, 5'h03, 5'h00, 1'b0, 1'b0);
    run_instr(4'h4, 2'h2, 3'h1, 1'b1, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h0c, 5'h02, 5'h00, 1'b0, 1'b0);
    run_instr(4'h2, 2'h2, 3'h0, 1'b0, 16'h0000, 8'h02, 5'h01, 5'h00,
      8'h0c, 5'h03, 5'h00, 1'b0, 1'b0);
    run_instr(4'ha, 2'h1, 3'h4, 1'b1, 16'h0000, 8'h06, 5'h01, 5'h00,
      8'h0c, 5'h02, 5'h00, 1'b0, 1'b0);
    run_instr(4'hc, 2'h2, 3'h3, 1'b1, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h08, 5'h02, 5'h00, 1'b0, 1'b0);
    run_instr(4'hb, 2'h2, 3'h5, 1'b1, 16'h0000, 8'h04, 5'h01, 5'h00,
      8'h2c, 5'h07, 5'h04, 1'b0, 1'b0);
    run_instr(4'h2, 2'h2, 3'h5, 1'b1, 16'h0000, 8'h08, 5'h02, 5'h00,
      8'h18, 5'h06, 5'h00, 1'b0, 1'b0);
    run_instr(4'hd, 2'h1, 3'h3, 1'b1, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h00, 5'h00, 5'h00, 1'b1, 1'b0);
    // multiply corners: worst case reaches the 74 clock ceiling
    run_instr(4'h6, 2'h1, 3'h0, 1'b0, 16'h5555, 8'h00, 5'h00, 5'h00,
      8'h4a, 5'h02, 5'h00, 1'b0, 1'b0);
    run_instr(4'h7, 2'h1, 3'h0, 1'b0, 16'hffff, 8'h00, 5'h00, 5'h00,
      8'h4a, 5'h02, 5'h00, 1'b0, 1'b0);
    run_instr(4'h6, 2'h1, 3'h0, 1'b0, 16'hffff, 8'h04, 5'h01, 5'h00,
      8'h30, 5'h03, 5'h00, 1'b0, 1'b0);
    run_instr(4'h7, 2'h1, 3'h0, 1'b0, 16'h0000, 8'h00, 5'h00, 5'h00,
      8'h2a, 5'h02, 5'h00, 1'b0, 1'b0);
    // divides report the maximum, with a start poked while busy
    run_instr(4'h8, 2'h1, 3'h0, 1'b0, 16'h1234, 8'h04, 5'h01, 5'h00,
      8'ha6, 5'h03, 5'h00, 1'b0, 1'b1);
    run_instr(4'h9, 2'h1, 3'h0, 1'b0, 16'h1234, 8'h00, 5'h00, 5'h00,
      8'h90, 5'h02, 5'h00, 1'b0, 1'b1);
    // random multiply operands, expectation from the bit-pattern count
    for (int i = 0; i < 24; i++)
    begin
      v = 16'($random(seed));
      sgn = 1'($random(seed));
      ec = 8'($random(seed)) & 8'h0e;
      n = mul_n(sgn, v);
      run_instr(sgn ? 4'h6 : 4'h7, 2'h1, 3'h0, 1'b0, v, ec, 5'h01, 5'h00,
        8'h2a + 8'(2 * n) + ec, 5'h03, 5'h00, 1'b0, 1'b0);
    end
    print_verdict();
  end
endmodule
`default_nettype wire
